//--- hdl/serial_status_pkg.sv
package serial_status_pkg;

	// Byte offsets of the register words on the bus
	localparam logic [3:0] OFF_STATUS = 4'h0;
	localparam logic [3:0] OFF_CONTROL = 4'h4;
	localparam logic [3:0] OFF_TXDATA = 4'h8;
	localparam logic [3:0] OFF_RXDATA = 4'hC;

	// Status bit positions
	localparam int BIT_TX_EMPTY = 7;
	localparam int BIT_RX_FULL = 6;
	localparam int BIT_OVERRUN = 5;
	localparam int BIT_FRAMING = 4;
	localparam int BIT_PARITY = 3;
	localparam int BIT_TX_DONE = 2;
	localparam int BIT_MP_RX = 1;
	localparam int BIT_MP_TX = 0;
	localparam logic [7:0] STATUS_RESET = 8'h84;

	// Control bit positions
	localparam int CTL_TX_ENABLE = 0;
	localparam int CTL_RX_ENABLE = 1;
	localparam int CTL_PARITY_ODD = 2;
	localparam int CTL_PARITY_EN = 3;
	localparam int CTL_SYNC_MODE = 4;
	localparam int CTL_MP_FORMAT = 5;
	localparam logic [5:0] CONTROL_RESET = 6'h00;

	// One finished character from the receive shifter
	typedef struct packed {
		logic done;
		logic [7:0] data;
		logic stopBit;
		logic parityBit;
		logic mpBit;
	} rx_char_s;

	// Transmit side view for the shifter
	typedef struct packed {
		logic [7:0] data;
		logic full;
		logic mpBit;
		logic halt;
	} tx_view_s;

endpackage

//--- hdl/serial_parity_check.sv
`timescale 1ns/10ps
`default_nettype none
module serial_parity_check (
	// Character and its parity bit
	input wire logic [7:0] charData,
	input wire logic parityBit,
	// Selection: 1 odd, 0 even
	input wire logic oddSelect,
	// Result
	output logic parityBad
);
	// Count of ones over data and parity must be odd for odd selection
	assign parityBad = ((^charData) ^ parityBit) != oddSelect;
endmodule
`default_nettype wire

//--- hdl/serial_status_flag_logic.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Status returns to 0x84 on reset and on low-power mode entry.
// - Five flags clear only by writing 0 after reading 1; 1 ignored.
// - tx_done and mp_bit_received ignore software writes.
// - tx_buffer_empty sets when holding data moves into the shifter.
// - tx_buffer_empty sets while tx_enable is 0.
// - Write to tx holding register or valid clear drops tx_buffer_empty.
// - Error-free finished character loads rx holding and sets rx_buffer_full.
// - Reading rx holding register or valid clear drops rx_buffer_full.
// - rx_enable off leaves rx holding and rx_buffer_full alone; errors leave only rx_buffer_full alone.
// - Character finishing with rx_buffer_full set raises overrun_flag.
// - On overrun the old character stays, the new one is lost.
// - Overrun halts reception; in synchronous mode also transmission.
// - Clearing rx_enable keeps overrun, framing and parity flags.
// - Async stop bit sampled 0 raises framing_flag.
// - Only the first stop bit is checked.
// - Framing error loads rx holding but not rx_buffer_full.
// - Framing flag halts reception; synchronous mode also transmission.
// - Async parity mismatch against odd/even selection raises parity_flag.
// - Parity error loads data without full flag; halts like other errors.
// - tx_done sets on tx off or last bit with empty buffer.
// - Async multiprocessor format captures received mp bit; kept when rx off.
// - mp_bit_to_send appended only in async multiprocessor transmit.
module serial_status_flag_logic (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Avalon-MM slave
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Low-power mode entry, one-cycle pulse
	input wire logic lowPowerEntry,
	// Transmit shifter events
	input wire logic txShiftLoad,
	input wire logic txLastBit,
	output serial_status_pkg::tx_view_s txView,
	// Receive shifter events
	input wire serial_status_pkg::rx_char_s rxChar,
	output logic rxHalt
);
	import serial_status_pkg::*;

	logic [7:0] status_q, status_d;
	logic [5:0] control_q;
	logic [7:0] txHold_q, rxHold_q;
	logic [4:0] armed_q;
	logic waitReq_q;
	logic [31:0] rdata_q;
	logic txFull_q, txMp_q, txHalt_q, rxHalt_q;
	logic access, wrAcc, rdAcc;
	logic stWrite, tdrWrite, rdrRead;
	logic [4:0] validClr;
	logic txEn, rxEn, syncMode, mpFormat;
	logic parityBad, rxTake, overrun, frameErr, parityErr, rxErr;

	// Address match used by every register decode
	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		return a[3:2] == off[3:2];
	endfunction

	// Bus handshake: waitrequest stays high for one cycle, then drops
	assign access = (read | write) & ~waitReq_q;
	assign wrAcc = write & ~waitReq_q;
	assign rdAcc = read & ~waitReq_q;
	assign stWrite = wrAcc & hit(address, OFF_STATUS) & byteenable[0];
	assign tdrWrite = wrAcc & hit(address, OFF_TXDATA) & byteenable[0];
	assign rdrRead = rdAcc & hit(address, OFF_RXDATA);

	assign txEn = control_q[CTL_TX_ENABLE];
	assign rxEn = control_q[CTL_RX_ENABLE];
	assign syncMode = control_q[CTL_SYNC_MODE];
	assign mpFormat = control_q[CTL_MP_FORMAT] & ~syncMode;

	// Wait state generator; request may not change while this is high
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			waitReq_q <= 1'b1;
		end else begin
			waitReq_q <= ~((read | write) & waitReq_q);
		end
	end

	// Read data is latched during the wait cycle so it stands at the ack edge
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 32'h0000_0000;
		end else if (read & waitReq_q) begin
			if (hit(address, OFF_STATUS)) begin
				rdata_q <= {24'h00_0000, status_q};
			end else if (hit(address, OFF_CONTROL)) begin
				rdata_q <= {26'h000_0000, control_q};
			end else if (hit(address, OFF_RXDATA)) begin
				rdata_q <= {24'h00_0000, rxHold_q};
			end else begin
				rdata_q <= 32'h0000_0000;
			end
		end
	end

	// Read arms a flag for clearing only if it was seen as 1
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			armed_q <= 5'h00;
		end else if (lowPowerEntry) begin
			armed_q <= 5'h00;
		end else if (rdAcc & hit(address, OFF_STATUS)) begin
			armed_q <= rdata_q[7:3];
		end else if (stWrite) begin
			armed_q <= armed_q & writedata[7:3];
		end
	end

	// A written 0 clears only an armed flag; a written 1 does nothing
	assign validClr = {5{stWrite}} & armed_q & ~writedata[7:3];

	// Control register
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			control_q <= CONTROL_RESET;
		end else if (wrAcc & hit(address, OFF_CONTROL) & byteenable[0]) begin
			control_q <= writedata[5:0];
		end
	end

	serial_parity_check parityCheck (
		.charData(rxChar.data),
		.parityBit(rxChar.parityBit),
		.oddSelect(control_q[CTL_PARITY_ODD]),
		.parityBad(parityBad)
	);

	// Receive classification; stopBit is the first stop bit only
	assign rxTake = rxChar.done & rxEn & ~rxHalt_q;
	assign overrun = rxTake & status_q[BIT_RX_FULL];
	assign frameErr = rxTake & ~syncMode & ~rxChar.stopBit;
	assign parityErr = rxTake & ~syncMode & control_q[CTL_PARITY_EN] &
		parityBad;
	assign rxErr = frameErr | parityErr;

	// Status next value; each set term is applied after its clear
	always_comb begin
		status_d = status_q;
		// Transmit empty: clear by data write or valid clear, set wins
		if (tdrWrite | validClr[4]) begin
			status_d[BIT_TX_EMPTY] = 1'b0;
		end
		if (txShiftLoad | ~txEn) begin
			status_d[BIT_TX_EMPTY] = 1'b1;
		end
		// Transmit done tracks the empty flag's clears
		if (tdrWrite | validClr[4]) begin
			status_d[BIT_TX_DONE] = 1'b0;
		end
		if (~txEn | (txLastBit & status_q[BIT_TX_EMPTY])) begin
			status_d[BIT_TX_DONE] = 1'b1;
		end
		// Receive full: no change on errors or with rx disabled
		if (rdrRead | validClr[3]) begin
			status_d[BIT_RX_FULL] = 1'b0;
		end
		if (rxTake & ~overrun & ~rxErr) begin
			status_d[BIT_RX_FULL] = 1'b1;
		end
		// Error flags; rx_enable plays no part in clearing them
		if (validClr[2]) begin
			status_d[BIT_OVERRUN] = 1'b0;
		end
		if (overrun) begin
			status_d[BIT_OVERRUN] = 1'b1;
		end
		if (validClr[1]) begin
			status_d[BIT_FRAMING] = 1'b0;
		end
		if (frameErr & ~overrun) begin
			status_d[BIT_FRAMING] = 1'b1;
		end
		if (validClr[0]) begin
			status_d[BIT_PARITY] = 1'b0;
		end
		if (parityErr & ~overrun) begin
			status_d[BIT_PARITY] = 1'b1;
		end
		// Received mp bit; held while reception is off
		if (rxTake & mpFormat & ~overrun) begin
			status_d[BIT_MP_RX] = rxChar.mpBit;
		end
		// Only the mp transmit bit is plainly writable
		if (stWrite) begin
			status_d[BIT_MP_TX] = writedata[BIT_MP_TX];
		end
		if (lowPowerEntry) begin
			status_d = STATUS_RESET;
		end
	end

	// Status register
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			status_q <= STATUS_RESET;
		end else begin
			status_q <= status_d;
		end
	end

	// Receive holding register; overrun keeps the older character
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rxHold_q <= 8'h00;
		end else if (rxTake & ~overrun) begin
			rxHold_q <= rxChar.data;
		end
	end

	// Transmit holding register
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			txHold_q <= 8'h00;
		end else if (tdrWrite) begin
			txHold_q <= writedata[7:0];
		end
	end

	// Shifter-facing outputs, registered from next-state values
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			txFull_q <= 1'b0;
			txMp_q <= 1'b0;
			txHalt_q <= 1'b0;
			rxHalt_q <= 1'b0;
		end else begin
			txFull_q <= ~status_d[BIT_TX_EMPTY];
			txMp_q <= status_d[BIT_MP_TX] & mpFormat & txEn;
			rxHalt_q <= |status_d[5:3];
			txHalt_q <= syncMode & (|status_d[5:3]);
		end
	end

	assign readdata = rdata_q;
	assign waitrequest = waitReq_q;
	assign rxHalt = rxHalt_q;
	assign txView = '{data: txHold_q, full: txFull_q, mpBit: txMp_q,
		halt: txHalt_q};

	// Checks
	property p_lowpower;
		@(posedge sys_clk) disable iff (!reset_n)
		lowPowerEntry |=> status_q == STATUS_RESET;
	endproperty
	a_lowpower: assert property (p_lowpower)
		else $error("status not 0x84 after low-power entry");

	property p_write_one;
		@(posedge sys_clk) disable iff (!reset_n)
		stWrite && writedata[BIT_RX_FULL] && !status_q[BIT_RX_FULL] &&
			!rxTake |=> !status_q[BIT_RX_FULL];
	endproperty
	a_write_one: assert property (p_write_one)
		else $error("software write of 1 set a flag");

	property p_unarmed;
		@(posedge sys_clk) disable iff (!reset_n)
		stWrite && !armed_q[2] && status_q[BIT_OVERRUN] |=>
			status_q[BIT_OVERRUN];
	endproperty
	a_unarmed: assert property (p_unarmed)
		else $error("flag cleared without prior read of 1");

	property p_readonly;
		@(posedge sys_clk) disable iff (!reset_n)
		stWrite && txEn && !txLastBit && !tdrWrite && !validClr[4] &&
			!rxTake && !lowPowerEntry |=> $stable(status_q[2:1]);
	endproperty
	a_readonly: assert property (p_readonly)
		else $error("read-only status bits changed by write");

	property p_tx_load;
		@(posedge sys_clk) disable iff (!reset_n)
		txShiftLoad |=> status_q[BIT_TX_EMPTY] && !txView.full;
	endproperty
	a_tx_load: assert property (p_tx_load)
		else $error("empty flag not set after shifter load");

	property p_tx_off;
		@(posedge sys_clk) disable iff (!reset_n)
		!txEn |=> status_q[BIT_TX_EMPTY] && status_q[BIT_TX_DONE];
	endproperty
	a_tx_off: assert property (p_tx_off)
		else $error("tx off did not force empty and done");

	property p_tdr_write;
		@(posedge sys_clk) disable iff (!reset_n)
		tdrWrite && txEn && !txShiftLoad && !txLastBit &&
			!lowPowerEntry |=> !status_q[BIT_TX_EMPTY] &&
			!status_q[BIT_TX_DONE];
	endproperty
	a_tdr_write: assert property (p_tdr_write)
		else $error("data write did not clear empty and done");

	property p_overrun;
		@(posedge sys_clk) disable iff (!reset_n)
		rxTake && status_q[BIT_RX_FULL] && !lowPowerEntry |=>
			status_q[BIT_OVERRUN] && $stable(rxHold_q) ##1 rxHalt;
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun not flagged or old data lost");

	property p_frame;
		@(posedge sys_clk) disable iff (!reset_n)
		frameErr && !overrun && !lowPowerEntry && !validClr[3] &&
			!rdrRead |=> status_q[BIT_FRAMING] &&
			rxHold_q == $past(rxChar.data) &&
			status_q[BIT_RX_FULL] == $past(status_q[BIT_RX_FULL]);
	endproperty
	a_frame: assert property (p_frame)
		else $error("framing error handling wrong");

	property p_halt;
		@(posedge sys_clk) disable iff (!reset_n)
		|status_q[5:3] |-> rxHalt_q && (txHalt_q == $past(syncMode));
	endproperty
	a_halt: assert property (p_halt)
		else $error("error flag did not halt shifters");

	property p_set_wins;
		@(posedge sys_clk) disable iff (!reset_n)
		validClr[4] && (txShiftLoad || !txEn) |=> status_q[BIT_TX_EMPTY];
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("clear beat a hardware set");

	c_clear: cover property (@(posedge sys_clk) validClr[3]);
	c_overrun: cover property (@(posedge sys_clk) overrun);
	c_parity: cover property (@(posedge sys_clk) parityErr && !frameErr);
	c_done: cover property (@(posedge sys_clk)
		txLastBit && status_q[BIT_TX_EMPTY] && txEn);

endmodule
`default_nettype wire

//--- verification/remote_serial_model.sv
`timescale 1ns/10ps
`default_nettype none
module remote_serial_model (
	// Clock
	input wire logic sys_clk,
	// Block side of the link
	input wire serial_status_pkg::tx_view_s txView,
	output serial_status_pkg::rx_char_s rxChar,
	output logic txShiftLoad,
	output logic txLastBit
);
	import serial_status_pkg::*;

	// Idle from time zero
	initial begin
		rxChar = '0;
		txShiftLoad = 1'b0;
		txLastBit = 1'b0;
	end

	// One finished character; fields outside done are scrambled so stale
	// values can never pass for a fresh character
	task automatic send(input logic [7:0] d, input logic stp, par, mp);
		@(posedge sys_clk);
		rxChar <= '{1'b1, d, stp, par, mp};
		@(posedge sys_clk);
		rxChar <= '{1'b0, ~d, ~stp, ~par, ~mp};
	endtask

	// Shifter takes the held byte once it is full, then shifts for gap cycles
	task automatic shift(input int gap, output bit late);
		int n;
		n = 0;
		while (txView.full !== 1'b1 && n < 20) begin
			@(posedge sys_clk);
			n++;
		end
		// Caller counts a shifter that never saw data as a failure
		late = (n >= 20);
		@(posedge sys_clk);
		txShiftLoad <= 1'b1;
		@(posedge sys_clk);
		txShiftLoad <= 1'b0;
		repeat (gap) @(posedge sys_clk);
		txLastBit <= 1'b1;
		@(posedge sys_clk);
		txLastBit <= 1'b0;
	endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import serial_status_pkg::*;

	logic sys_clk, reset_n, read, write, lowPowerEntry, waitrequest;
	logic txShiftLoad, txLastBit, rxHalt;
	logic [3:0] address, byteenable;
	logic [31:0] writedata, readdata;
	tx_view_s txView;
	rx_char_s rxChar;
	int failures, cmp_count;
	logic [7:0] rv;
	bit late;

	// Clock at 40 MHz
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	serial_status_flag_logic i_serial_status_flag_logic (
		.sys_clk(sys_clk), .reset_n(reset_n), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .lowPowerEntry(lowPowerEntry),
		.txShiftLoad(txShiftLoad), .txLastBit(txLastBit), .txView(txView),
		.rxChar(rxChar), .rxHalt(rxHalt)
	);

	remote_serial_model i_remote_serial_model (
		.sys_clk(sys_clk), .txView(txView), .rxChar(rxChar),
		.txShiftLoad(txShiftLoad), .txLastBit(txLastBit)
	);

	task automatic test_done();
		if (failures == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One bus cycle; request held until waitrequest is sampled low
	task automatic bus(input logic rd, input logic [3:0] a, input logic [7:0] wd);
		int n;
		@(posedge sys_clk);
		read <= rd;
		write <= ~rd;
		address <= a;
		writedata <= {24'h000000, wd};
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 40);
		rv = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 40) begin
			failures++;
			test_done();
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b0, a, d);
	endtask

	task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string nm);
		bus(1'b1, a, 8'h00);
		chk(nm, rv, exp);
	endtask

	// Control write, then let the flags reach txView and rxHalt
	task automatic ctl(input logic [7:0] d);
		wr(OFF_CONTROL, d);
		repeat (3) @(posedge sys_clk);
	endtask

	initial begin
		failures = 0;
		cmp_count = 0;
		read = 1'b0;
		write = 1'b0;
		address = 4'h0;
		writedata = 32'h00000000;
		byteenable = 4'hF;
		lowPowerEntry = 1'b0;
		reset_n = 1'b0;
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		rdc(OFF_STATUS, 8'h84, "status reset");
		// Ones on flags do nothing; only the mp send bit takes them
		wr(OFF_STATUS, 8'hFF);
		rdc(OFF_STATUS, 8'h85, "status after ones");
		ctl(8'h03);
		wr(OFF_TXDATA, 8'h5A);
		rdc(OFF_STATUS, 8'h01, "status tx loaded");
		chk("tx holding", txView.data, 8'h5A);
		chk("tx full", {7'h00, txView.full}, 8'h01);
		i_remote_serial_model.shift(4, late);
		if (late) begin
			failures++;
			test_done();
		end
		rdc(OFF_STATUS, 8'h85, "status tx sent");
		chk("tx not full", {7'h00, txView.full}, 8'h00);
		// Appended mp bit only in async multiprocessor transmit
		ctl(8'h23);
		chk("mp to send async", {7'h00, txView.mpBit}, 8'h01);
		ctl(8'h33);
		chk("mp to send sync", {7'h00, txView.mpBit}, 8'h00);
		ctl(8'h23);
		i_remote_serial_model.send(8'h44, 1'b1, 1'b0, 1'b1);
		rdc(OFF_STATUS, 8'hC7, "status mp rx");
		wr(OFF_STATUS, 8'hBF);
		rdc(OFF_STATUS, 8'h87, "status rx full clr");
		rdc(OFF_RXDATA, 8'h44, "rx data mp");
		ctl(8'h01);
		rdc(OFF_STATUS, 8'h87, "status rx off");
		ctl(8'h03);
		// Overrun: second char lost, clear without a fresh read refused
		i_remote_serial_model.send(8'h11, 1'b1, 1'b0, 1'b0);
		i_remote_serial_model.send(8'h22, 1'b1, 1'b0, 1'b0);
		wr(OFF_STATUS, 8'hDD);
		rdc(OFF_STATUS, 8'hE7, "status overrun");
		chk("halt overrun", {7'h00, rxHalt}, 8'h01);
		rdc(OFF_RXDATA, 8'h11, "rx data overrun");
		wr(OFF_STATUS, 8'hDD);
		rdc(OFF_STATUS, 8'h87, "status overrun clr");
		// Framing error loads data without full, then blocks reception
		i_remote_serial_model.send(8'h77, 1'b0, 1'b0, 1'b0);
		rdc(OFF_STATUS, 8'h97, "status framing");
		i_remote_serial_model.send(8'h99, 1'b1, 1'b0, 1'b0);
		rdc(OFF_RXDATA, 8'h77, "rx data framing");
		ctl(8'h01);
		rdc(OFF_STATUS, 8'h97, "status framing rx off");
		wr(OFF_STATUS, 8'hED);
		rdc(OFF_STATUS, 8'h87, "status framing clr");
		// Odd parity selected: one data one plus parity one is wrong
		ctl(8'h0F);
		i_remote_serial_model.send(8'h01, 1'b1, 1'b1, 1'b0);
		rdc(OFF_STATUS, 8'h8F, "status parity");
		chk("halt parity", {7'h00, rxHalt}, 8'h01);
		rdc(OFF_RXDATA, 8'h01, "rx data parity");
		wr(OFF_STATUS, 8'hF5);
		rdc(OFF_STATUS, 8'h87, "status parity clr");
		// Even parity accepts two ones; sync overrun halts the transmitter
		ctl(8'h0B);
		i_remote_serial_model.send(8'h03, 1'b1, 1'b0, 1'b0);
		rdc(OFF_STATUS, 8'hC7, "status even parity");
		ctl(8'h13);
		i_remote_serial_model.send(8'h66, 1'b0, 1'b0, 1'b0);
		rdc(OFF_STATUS, 8'hE7, "status sync overrun");
		chk("tx halt sync", {7'h00, txView.halt}, 8'h01);
		rdc(OFF_RXDATA, 8'h03, "rx data sync");
		wr(OFF_STATUS, 8'hDD);
		rdc(OFF_STATUS, 8'h87, "status sync clr");
		chk("tx halt clr", {7'h00, txView.halt}, 8'h00);
		// Dropping tx enable refills the empty and done flags
		wr(OFF_TXDATA, 8'hAA);
		ctl(8'h0E);
		rdc(OFF_STATUS, 8'h87, "status tx off");
		@(posedge sys_clk);
		lowPowerEntry <= 1'b1;
		@(posedge sys_clk);
		lowPowerEntry <= 1'b0;
		rdc(OFF_STATUS, 8'h84, "status low power");
		// Clear of the empty flag loses to tx disabled holding it set
		wr(OFF_STATUS, 8'h00);
		rdc(OFF_STATUS, 8'h84, "status set wins");
		test_done();
	end
endmodule
`default_nettype wire
